/* File: hdl/lcc_pkg.sv */
`default_nettype none
package lcc_pkg;
	// control memory byte addresses
	localparam logic [7:0] ADDR_ACTIVATION = 8'h81;
	localparam logic [7:0] ADDR_DIRECTION  = 8'h9e;
	localparam logic [7:0] ADDR_OUT_VALUE  = 8'h9f;
	localparam logic [7:0] ADDR_LEAD_STATE = 8'ha0;

	// channel_activation fields
	localparam int ACT_BIT  = 0;
	localparam int LOOP_LSB = 1;
	localparam int LOOP_MSB = 3;

	// reset values
	localparam logic [7:0] ACT_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'h0c;
	localparam logic [7:0] OUT_RESET = 8'h00;

	// block shape
	localparam int NUM_CH    = 4;
	localparam int NUM_LEADS = 6;
	localparam int SAMPLE_W  = 8;

	typedef enum logic [2:0] {
		LCC_LOOP_NONE     = 3'b000,
		LCC_LOOP_DIG_PCM  = 3'b001,
		LCC_LOOP_DIG_CONV = 3'b010,
		LCC_LOOP_DIG_FULL = 3'b011,
		LCC_LOOP_ANA_DSM  = 3'b100,
		LCC_LOOP_ANA_PCM  = 3'b101
	} lcc_loop_t;
endpackage
`default_nettype wire

/* File: hdl/lcc_line_channel_control.sv */
// Notes on behaviour
// - standby after reset or activation bit 0
// - register and lead access work in standby
// - standby ignores analog and PCM inputs
// - digital loop returns PCM receive to transmit
// - digital loop at conversion boundary
// - digital loop after full processing chain
// - analog loop at delta-sigma digital side
// - analog loop at PCM interface
// - equal time slots loop own PCM back
// - direction location selects lead in/out
// - output value reaches leads within a frame
// - lead state sampled every frame strobe
// - channel reset floats leads 0,1,4,5
// - channel reset drives leads 2,3 low
// - fast scan returns leads 0,1 all channels
// - reads never disturb channel operation
// - fast scan is one byte, one reply
// - scan reply bit 2n,2n+1 per channel
`timescale 1ns/100ps
`default_nettype none
module lcc_line_channel_control #(
	parameter int NUM_LEADS = lcc_pkg::NUM_LEADS,
	parameter int SAMPLE_W  = lcc_pkg::SAMPLE_W
) (
	input  wire logic                                      i_clk,
	input  wire logic                                      i_rst_n,
	input  wire logic [lcc_pkg::NUM_CH-1:0]                i_chan_reset,
	input  wire logic                                      i_frame_strobe,
	input  wire logic                                      i_wr_en,
	input  wire logic                                      i_rd_en,
	input  wire logic [1:0]                                i_chan,
	input  wire logic [7:0]                                i_addr,
	input  wire logic [7:0]                                i_wdata,
	output logic      [7:0]                                o_rdata,
	output logic                                           o_rd_valid,
	input  wire logic                                      i_scan_req,
	output logic      [7:0]                                o_scan_data,
	output logic                                           o_scan_valid,
	input  wire logic [lcc_pkg::NUM_CH-1:0][NUM_LEADS-1:0] i_lead_in,
	output logic      [lcc_pkg::NUM_CH-1:0][NUM_LEADS-1:0] o_lead_out,
	output logic      [lcc_pkg::NUM_CH-1:0][NUM_LEADS-1:0] o_lead_oe,
	input  wire logic [lcc_pkg::NUM_CH-1:0][SAMPLE_W-1:0]  i_pcm_rx,
	input  wire logic [lcc_pkg::NUM_CH-1:0][SAMPLE_W-1:0]  i_adc_data,
	input  wire logic [lcc_pkg::NUM_CH-1:0]                i_slots_equal,
	output logic      [lcc_pkg::NUM_CH-1:0][SAMPLE_W-1:0]  o_pcm_tx,
	output logic      [lcc_pkg::NUM_CH-1:0][SAMPLE_W-1:0]  o_dac_data,
	output logic      [lcc_pkg::NUM_CH-1:0]                o_active
);
	localparam int NCH = lcc_pkg::NUM_CH;

	function automatic logic [7:0] lead_mask();
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 8; i++) begin
			m[i] = (i < NUM_LEADS);
		end
		return m;
	endfunction

	function automatic logic [7:0] widen(input logic [NUM_LEADS-1:0] v);
		logic [7:0] w;
		w = 8'h00;
		for (int i = 0; i < NUM_LEADS; i++) begin
			w[i] = v[i];
		end
		return w;
	endfunction

	localparam logic [7:0] MASK = lead_mask();

	// control memory
	logic [NCH-1:0][7:0] chan_act;
	logic [NCH-1:0][7:0] lead_dir;
	logic [NCH-1:0][7:0] lead_val;
	logic [NCH-1:0][7:0] lead_state;
	logic [NCH-1:0][7:0] next_chan_act;
	logic [NCH-1:0][7:0] next_lead_dir;
	logic [NCH-1:0][7:0] next_lead_val;
	logic [NCH-1:0][7:0] next_lead_state;
	logic [NCH-1:0][NUM_LEADS-1:0] next_lead_out;
	logic [NCH-1:0][NUM_LEADS-1:0] next_lead_oe;

	// register and lead group
	always_comb begin
		next_chan_act   = chan_act;
		next_lead_dir   = lead_dir;
		next_lead_val   = lead_val;
		next_lead_state = lead_state;
		next_lead_out   = o_lead_out;
		next_lead_oe    = o_lead_oe;
		for (int c = 0; c < NCH; c++) begin
			// writes land in standby too; reads touch nothing here
			if (i_wr_en && i_chan == 2'(c)) begin
				case (i_addr)
					lcc_pkg::ADDR_ACTIVATION: begin
						next_chan_act[c] = i_wdata;
					end
					lcc_pkg::ADDR_DIRECTION: begin
						next_lead_dir[c] = i_wdata & MASK;
					end
					lcc_pkg::ADDR_OUT_VALUE: begin
						next_lead_val[c] = i_wdata & MASK;
					end
					default: begin
						next_chan_act[c] = next_chan_act[c];
					end
				endcase
			end
			// outside channel reset, leads only move on the frame strobe, so writes land
			// within one frame and inputs are frame-synchronous
			if (i_frame_strobe) begin
				next_lead_out[c]   = lead_val[c][NUM_LEADS-1:0];
				next_lead_oe[c]    = lead_dir[c][NUM_LEADS-1:0];
				next_lead_state[c] = widen(i_lead_in[c]);
			end
			if (i_chan_reset[c]) begin
				next_chan_act[c] = lcc_pkg::ACT_RESET;
				next_lead_dir[c] = lcc_pkg::DIR_RESET & MASK;
				next_lead_val[c] = lcc_pkg::OUT_RESET;
				// reset acts at once, not at the next frame
				next_lead_oe[c]  = NUM_LEADS'(lcc_pkg::DIR_RESET);
				next_lead_out[c] = '0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			for (int c = 0; c < NCH; c++) begin
				chan_act[c]   <= lcc_pkg::ACT_RESET;
				lead_dir[c]   <= lcc_pkg::DIR_RESET & MASK;
				lead_val[c]   <= lcc_pkg::OUT_RESET;
				lead_state[c] <= 8'h00;
				o_lead_oe[c]  <= NUM_LEADS'(lcc_pkg::DIR_RESET);
				o_lead_out[c] <= '0;
			end
		end else begin
			chan_act   <= next_chan_act;
			lead_dir   <= next_lead_dir;
			lead_val   <= next_lead_val;
			lead_state <= next_lead_state;
			o_lead_out <= next_lead_out;
			o_lead_oe  <= next_lead_oe;
		end
	end

	// read and fast scan answers
	logic [7:0] next_rdata;
	logic [7:0] next_scan_data;

	always_comb begin
		case (i_addr)
			lcc_pkg::ADDR_ACTIVATION: next_rdata = chan_act[i_chan];
			lcc_pkg::ADDR_DIRECTION:  next_rdata = lead_dir[i_chan] & MASK;
			lcc_pkg::ADDR_OUT_VALUE:  next_rdata = lead_val[i_chan] & MASK;
			lcc_pkg::ADDR_LEAD_STATE: next_rdata = lead_state[i_chan] & MASK;
			default:                  next_rdata = 8'h00;
		endcase
		if (!i_rd_en) begin
			next_rdata = o_rdata;
		end
		next_scan_data = o_scan_data;
		if (i_scan_req) begin
			for (int c = 0; c < NCH; c++) begin
				next_scan_data[2*c]   = lead_state[c][0];
				next_scan_data[2*c+1] = lead_state[c][1];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata      <= 8'h00;
			o_rd_valid   <= 1'b0;
			o_scan_data  <= 8'h00;
			o_scan_valid <= 1'b0;
		end else begin
			o_rdata      <= next_rdata;
			o_rd_valid   <= i_rd_en;
			o_scan_data  <= next_scan_data;
			o_scan_valid <= i_scan_req;
		end
	end

	// sample path with loopbacks, one sample per frame per channel
	logic [NCH-1:0][SAMPLE_W-1:0] next_pcm_tx;
	logic [NCH-1:0][SAMPLE_W-1:0] next_dac;
	logic [NCH-1:0]               next_active;

	always_comb begin
		logic [SAMPLE_W-1:0] rx_s;
		logic [SAMPLE_W-1:0] adc_s;
		lcc_pkg::lcc_loop_t  mode;
		rx_s        = '0;
		adc_s       = '0;
		mode        = lcc_pkg::LCC_LOOP_NONE;
		next_pcm_tx = o_pcm_tx;
		next_dac    = o_dac_data;
		for (int c = 0; c < NCH; c++) begin
			next_active[c] = next_chan_act[c][lcc_pkg::ACT_BIT];
			mode  = lcc_pkg::lcc_loop_t'(
				chan_act[c][lcc_pkg::LOOP_MSB:lcc_pkg::LOOP_LSB]);
			rx_s  = i_pcm_rx[c];
			adc_s = i_adc_data[c];
			if (i_slots_equal[c]) begin
				rx_s = o_pcm_tx[c];
			end
			if (i_frame_strobe) begin
				case (mode)
					lcc_pkg::LCC_LOOP_DIG_PCM: begin
						next_pcm_tx[c] = rx_s;
						next_dac[c]    = rx_s;
					end
					lcc_pkg::LCC_LOOP_DIG_CONV: begin
						next_dac[c]    = rx_s;
						next_pcm_tx[c] = rx_s;
					end
					lcc_pkg::LCC_LOOP_DIG_FULL: begin
						// one frame later: passes the converter stage
						next_dac[c]    = rx_s;
						next_pcm_tx[c] = o_dac_data[c];
					end
					lcc_pkg::LCC_LOOP_ANA_DSM: begin
						next_dac[c]    = adc_s;
						next_pcm_tx[c] = adc_s;
					end
					lcc_pkg::LCC_LOOP_ANA_PCM: begin
						next_pcm_tx[c] = adc_s;
						next_dac[c]    = o_pcm_tx[c];
					end
					default: begin
						next_pcm_tx[c] = adc_s;
						next_dac[c]    = rx_s;
					end
				endcase
				// standby drops both inputs; only idle code leaves
				if (!chan_act[c][lcc_pkg::ACT_BIT]) begin
					next_pcm_tx[c] = '0;
					next_dac[c]    = '0;
				end
			end
			if (i_chan_reset[c]) begin
				next_pcm_tx[c] = '0;
				next_dac[c]    = '0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_pcm_tx   <= '0;
			o_dac_data <= '0;
			o_active   <= '0;
		end else begin
			o_pcm_tx   <= next_pcm_tx;
			o_dac_data <= next_dac;
			o_active   <= next_active;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_standby_entry: assert property (
		i_wr_en && i_chan == 2'd0 && i_addr == lcc_pkg::ADDR_ACTIVATION
		&& !i_wdata[0] |=> !o_active[0] && !chan_act[0][0])
		else $error("activation write did not enter standby");
	a_standby_ignore: assert property (
		i_frame_strobe && !chan_act[0][0]
		|=> o_pcm_tx[0] == '0 && o_dac_data[0] == '0)
		else $error("standby channel passed input data");
	a_read_answer: assert property (
		i_rd_en && i_chan == 2'd0 && i_addr == lcc_pkg::ADDR_ACTIVATION
		|=> o_rd_valid && o_rdata == $past(chan_act[0]))
		else $error("activation read returned wrong value");
	a_read_quiet: assert property (
		i_rd_en && !i_wr_en && i_chan_reset == '0
		|=> $stable(chan_act) && $stable(lead_dir) && $stable(lead_val))
		else $error("read changed control memory");
	a_lead_update: assert property (
		i_frame_strobe && !i_chan_reset[0]
		|=> o_lead_out[0] == $past(lead_val[0][NUM_LEADS-1:0])
		&& o_lead_oe[0] == $past(lead_dir[0][NUM_LEADS-1:0]))
		else $error("leads not updated on frame strobe");
	a_lead_sample: assert property (
		i_frame_strobe && !i_chan_reset[0]
		|=> lead_state[0] == widen($past(i_lead_in[0])))
		else $error("lead state not sampled on frame strobe");
	a_chan_reset: assert property (
		i_chan_reset[0] |=> o_lead_oe[0] == NUM_LEADS'(lcc_pkg::DIR_RESET)
		&& o_lead_out[0] == '0 && !o_active[0])
		else $error("channel reset lead defaults wrong");
	a_scan_reply: assert property (
		i_scan_req |=> o_scan_valid
		&& o_scan_data[1:0] == $past(lead_state[0][1:0])
		&& o_scan_data[7:6] == $past(lead_state[3][1:0]))
		else $error("fast scan reply byte wrong");
	a_scan_single: assert property (
		i_scan_req ##1 !i_scan_req |=> !o_scan_valid)
		else $error("fast scan gave more than one reply");
	a_dig_loop: assert property (
		i_frame_strobe && chan_act[0][0] && !i_chan_reset[0]
		&& !i_slots_equal[0] && chan_act[0][3:1] == 3'b001
		|=> o_pcm_tx[0] == $past(i_pcm_rx[0]))
		else $error("PCM digital loopback broken");
	a_conv_loop: assert property (
		i_frame_strobe && chan_act[0][0] && !i_chan_reset[0]
		&& !i_slots_equal[0] && chan_act[0][3:1] == 3'b010
		|=> o_pcm_tx[0] == $past(i_pcm_rx[0])
		&& o_dac_data[0] == $past(i_pcm_rx[0]))
		else $error("conversion boundary loopback broken");
	a_full_loop: assert property (
		i_frame_strobe && chan_act[0][0] && !i_chan_reset[0]
		&& chan_act[0][3:1] == 3'b011
		|=> o_pcm_tx[0] == $past(o_dac_data[0]))
		else $error("full chain loopback broken");
	a_ana_loop: assert property (
		i_frame_strobe && chan_act[0][0] && !i_chan_reset[0]
		&& chan_act[0][3:1] == 3'b100
		|=> o_dac_data[0] == $past(i_adc_data[0])
		&& o_pcm_tx[0] == $past(i_adc_data[0]))
		else $error("converter side analog loopback broken");
	a_ana_pcm: assert property (
		i_frame_strobe && chan_act[0][0] && !i_chan_reset[0]
		&& chan_act[0][3:1] == 3'b101
		|=> o_dac_data[0] == $past(o_pcm_tx[0]))
		else $error("PCM side analog loopback broken");
	a_slot_loop: assert property (
		i_frame_strobe && chan_act[0][0] && !i_chan_reset[0]
		&& i_slots_equal[0] && chan_act[0][3:1] == 3'b001
		|=> o_pcm_tx[0] == $past(o_pcm_tx[0]))
		else $error("equal time slot loopback broken");
	// upper bits must stay clear so reads of absent leads give zero
	a_lead_mask: assert property (
		(lead_dir[0] & ~MASK) == 8'h00 && (lead_val[0] & ~MASK) == 8'h00
		&& (lead_state[0] & ~MASK) == 8'h00)
		else $error("absent lead bits stored as nonzero");

	c_scan: cover property (i_scan_req ##1 o_scan_valid);
	c_active_frame: cover property (o_active[0] && i_frame_strobe);
	c_reset_then_write: cover property (
		i_chan_reset[0] ##[1:8] i_wr_en && i_addr == lcc_pkg::ADDR_OUT_VALUE);
	c_full_loop: cover property (
		i_frame_strobe && chan_act[0][0] && chan_act[0][3:1] == 3'b011);
	c_slots_equal: cover property (
		i_frame_strobe && chan_act[0][0] && i_slots_equal[0]);
endmodule
`default_nettype wire

/* File: verif/lcc_line_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module lcc_line_partner (
	input  wire logic [3:0][5:0] i_lead_out,
	input  wire logic [3:0][5:0] i_lead_oe,
	input  wire logic [3:0][5:0] i_ext,
	output logic      [3:0][5:0] o_lead_in
);
	// a released lead shows the switch or resistor level, not the old drive
	assign o_lead_in = (i_lead_out & i_lead_oe) | (i_ext & ~i_lead_oe);
endmodule
`default_nettype wire

/* File: verif/line_channel_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module line_channel_control_bench;
	logic            i_clk = 1'b0;
	logic            i_rst_n, fs, wr, rd, scan, rv, sv;
	logic [3:0]      crst, seq;
	logic [1:0]      ch;
	logic [7:0]      addr, wd, rdata, sdata, pt, pd, r, et, ed;
	logic [3:0][5:0] lin, lout, loe, ext, md, mo, lvl;
	logic [3:0][7:0] rx, adc, tx, dac;
	logic [3:0]      act;
	logic [7:0]      rq[$], sq[$];
	logic [31:0]     lf;
	int              miscompares, check_count;

	always #5 i_clk = ~i_clk; // free running, standby included

	lcc_line_channel_control i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_chan_reset(crst), .i_frame_strobe(fs), .i_wr_en(wr),
		.i_rd_en(rd), .i_chan(ch), .i_addr(addr), .i_wdata(wd),
		.o_rdata(rdata), .o_rd_valid(rv), .i_scan_req(scan),
		.o_scan_data(sdata), .o_scan_valid(sv), .i_lead_in(lin),
		.o_lead_out(lout), .o_lead_oe(loe), .i_pcm_rx(rx),
		.i_adc_data(adc), .i_slots_equal(seq), .o_pcm_tx(tx),
		.o_dac_data(dac), .o_active(act));
	lcc_line_partner i_line (.i_lead_out(lout), .i_lead_oe(loe),
		.i_ext(ext), .o_lead_in(lin));

	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction
	task automatic chk(input string n, input logic [7:0] s, e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wrt(input logic [1:0] c, input logic [7:0] a, d);
		@(negedge i_clk);
		{wr, ch, addr, wd} = {1'b1, c, a, d};
		@(negedge i_clk);
		wr = 1'b0;
	endtask
	task automatic rdx(input logic [1:0] c, input logic [7:0] a, e);
		@(negedge i_clk);
		{rd, ch, addr} = {1'b1, c, a};
		rq.push_back(e);
		@(negedge i_clk);
		rd = 1'b0;
	endtask
	task automatic strobe();
		@(negedge i_clk);
		fs = 1'b1;
		@(negedge i_clk);
		fs = 1'b0;
	endtask
	task automatic leads();
		for (int c = 0; c < 4; c++) begin
			chk("lead_oe", 8'(loe[c]), 8'(md[c]));
			chk("lead_out", 8'(lout[c]), 8'(mo[c]));
		end
	endtask

	// replies are matched in order against the notes queued by the driver
	always @(negedge i_clk) begin
		if (rv)
			chk("rdata", rdata, rq.pop_front());
		if (sv)
			chk("scan", sdata, sq.pop_front());
	end

	initial begin
		repeat (40000) @(posedge i_clk);
		miscompares++;
		finish_test();
	end

	initial begin
		{i_rst_n, fs, wr, rd, scan, crst, seq, ch, addr, wd} = '0;
		{rx, adc, ext} = '0;
		lf = 32'h0204;
		md = {4{6'h0c}};
		mo = '0;
		repeat (16) @(negedge i_clk);
		i_rst_n = 1'b1;
		leads();
		for (int c = 0; c < 4; c++) begin
			rdx(2'(c), lcc_pkg::ADDR_ACTIVATION, 8'h00);
			rdx(2'(c), lcc_pkg::ADDR_DIRECTION, 8'h0c);
			md[c] = 6'(rnd());
			mo[c] = 6'(rnd());
			wrt(2'(c), lcc_pkg::ADDR_DIRECTION, {2'b11, md[c]});
			wrt(2'(c), lcc_pkg::ADDR_OUT_VALUE, {2'b11, mo[c]});
			wrt(2'(c), lcc_pkg::ADDR_LEAD_STATE, 8'hff);
			rdx(2'(c), lcc_pkg::ADDR_OUT_VALUE, {2'b00, mo[c]});
			rdx(2'(c), 8'h55, 8'h00);
		end
		ext = 24'(rnd());
		strobe();
		leads();
		// state samples the pad levels present at the following strobe
		strobe();
		lvl = (mo & md) | (ext & ~md);
		for (int c = 0; c < 4; c++)
			rdx(2'(c), lcc_pkg::ADDR_LEAD_STATE, {2'b00, lvl[c]});
		for (int k = 0; k < 2; k++) begin
			@(negedge i_clk);
			scan = 1'b1;
			sq.push_back({lvl[3][1:0], lvl[2][1:0], lvl[1][1:0],
				lvl[0][1:0]});
			@(negedge i_clk);
			scan = 1'b0;
		end
		rx = 32'(rnd());
		adc = 32'(rnd());
		strobe();
		chk("tx_standby", tx[0], 8'h00);
		chk("dac_standby", dac[0], 8'h00);
		pt = '0;
		pd = '0;
		for (int m = 0; m < 6; m++) begin
			wrt(2'd0, lcc_pkg::ADDR_ACTIVATION, {4'h0, 3'(m), 1'b1});
			chk("active", 8'(act), 8'h01);
			seq = {3'b000, m[0]};
			repeat (2) begin
				rx = 32'(rnd());
				adc = 32'(rnd());
				r = seq[0] ? pt : rx[0];
				case (m)
					0: {et, ed} = {adc[0], r};
					1, 2: {et, ed} = {r, r};
					3: {et, ed} = {pd, r};
					4: {et, ed} = {adc[0], adc[0]};
					default: {et, ed} = {adc[0], pt};
				endcase
				strobe();
				chk("pcm_tx", tx[0], et);
				chk("dac", dac[0], ed);
				{pt, pd} = {et, ed};
			end
		end
		rdx(2'd0, lcc_pkg::ADDR_ACTIVATION, 8'h0b);
		chk("tx_after_read", tx[0], pt);
		wrt(2'd0, lcc_pkg::ADDR_ACTIVATION, 8'h00);
		chk("standby", 8'(act), 8'h00);
		strobe();
		chk("tx_idle", tx[0], 8'h00);
		@(negedge i_clk);
		crst = 4'b0001;
		@(negedge i_clk);
		crst = 4'b0000;
		md[0] = 6'h0c;
		mo[0] = 6'h00;
		leads();
		repeat (25600) @(negedge i_clk);
		rdx(2'd0, lcc_pkg::ADDR_DIRECTION, 8'h0c);
		repeat (4) @(negedge i_clk);
		chk("pending", 8'(rq.size() + sq.size()), 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
